// ==== pkg/mtc_defines.svh ====
/*
  Offsets, field positions, reset values and timing counts of the
  measurement trigger control block. Assumes a 250 MHz hclk.
*/
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH
`define MTC_A_CTRL    8'h00
`define MTC_A_COUNT   8'h04
`define MTC_A_CMD     8'h08
`define MTC_A_STEP    8'h0C
`define MTC_A_LOWER   8'h10
`define MTC_A_UPPER   8'h14
`define MTC_A_PERIOD  8'h18
`define MTC_A_STATUS  8'h1C
`define MTC_A_TDIFF   8'h20
`define MTC_F_MODE    2:0
`define MTC_F_POL     3
`define MTC_F_VAR     4
`define MTC_F_ROLE    6:5
`define MTC_F_ENC     8:7
`define MTC_F_START   0
`define MTC_F_STOP    1
`define MTC_R_CTRL    9'h000
`define MTC_R_COUNT   14'h0001
`define MTC_R_STEP    32'h0000_0001
`define MTC_R_LOWER   32'h0000_0000
`define MTC_R_UPPER   32'hFFFF_FFFF
`define MTC_R_PERIOD  24'h00_0FA0
`define MTC_CLK_MHZ   250
`define MTC_EXP_OFS_NS 100
`define MTC_EXP_CYC ((`MTC_EXP_OFS_NS * `MTC_CLK_MHZ + 999) / 1000)
`endif

// ==== pkg/mtc_pkg.sv ====
/*
  Types of the measurement trigger control block.
  Assumes mtc_defines.svh for all numbers.
*/
package mtc_pkg;
  typedef enum logic [2:0] {
    M_NONE, M_LEVEL, M_EDGE, M_SOFT, M_ENC
  } mtc_mode_e;
  typedef enum logic [1:0] {R_LOCAL, R_MASTER, R_SLAVE} mtc_role_e;
endpackage

// ==== pkg/mtc_pin_if.sv ====
/*
  Carrier between the top and its input synchroniser.
  Assumes raw is driven from the sync input pin.
*/
`timescale 1ns/1ps
`default_nettype none
interface mtc_pin_if;
  logic raw;
  logic sync;
  modport sync_side (input raw, output sync);
  modport user      (output raw, input sync);
endinterface
`default_nettype wire

// ==== rtl/mtc_sync2.sv ====
/*
  Two flip-flop synchroniser for the sync input pin.
  Assumes the pin is asynchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module mtc_sync2 (
  input wire logic     hclk,
  input wire logic     hresetn,
  input wire logic     ce,
  mtc_pin_if.sync_side pins
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= pins.raw;  // see RULE_21
      sync_ff <= meta_ff;
    end
  end

  assign pins.sync = sync_ff;
endmodule // mtc_sync2
`default_nettype wire

// ==== rtl/mtc_top.sv ====
/*
  Trigger and cycle synchronisation control of a measurement
  controller, with an AHB-Lite register slave.
  Assumes hclk at 250 MHz, encoder counts on hclk, sync pin async.
*/
// Operation
// RULE_01: Sync input pin serves as trigger input in electrical modes.
// RULE_02: After reset triggering is off and values flow every cycle.
// RULE_03: Trigger modes never change the measurement cycle rate.
// RULE_04: Gating applies alike to analog and digital output paths.
// RULE_05: Source holds each trigger pulse for at least 5 us.
// RULE_06: Level mode emits every cycle while input sits at active level.
// RULE_07: Level source keeps active and inactive phases one cycle each.
// RULE_08: Selected edge starts a burst of 1 to 16383 measurements.
// RULE_09: After a burst the analog output holds its last value.
// RULE_10: Start command launches a burst; stop command ends it early.
// RULE_11: Encoder mode triggers from one of three encoders per condition.
// RULE_12: Encoder triggers each step between lower and upper limit.
// RULE_13: Acquisition variant processes samples only after a valid trigger.
// RULE_14: Output variant computes every cycle, trigger only releases output.
// RULE_15: Both variants have identical trigger to output timing.
// RULE_16: Cycle start to trigger interval is emitted three cycles later.
// RULE_17: Cycle start precedes exposure end by a fixed 100 ns.
// RULE_18: Master drives sync output so followers run in step.
// RULE_19: Slave takes its cycle from sync input pulses.
// RULE_20: External sync source runs no slower than 0.110 to 0.370 kHz.
// RULE_21: Asynchronous inputs pass two flip-flops before any detection.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defines.svh"
module mtc_top import mtc_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sync_in,
  input  wire logic [31:0] enc_pos_0,
  input  wire logic [31:0] enc_pos_1,
  input  wire logic [31:0] enc_pos_2,
  output logic             sync_out,
  output logic             cyc_start,
  output logic             exp_end,
  output logic             acq_en,
  output logic             ana_out_en,
  output logic             dig_out_en,
  output logic             ana_hold,
  output logic             tdiff_valid,
  output logic      [23:0] tdiff
);
  localparam logic [7:0] EXP_CYC = 8'(`MTC_EXP_CYC);

  logic [8:0]  ctrl_ff;
  logic [13:0] count_ff;
  logic [31:0] step_ff;
  logic [31:0] lower_ff;
  logic [31:0] upper_ff;
  logic [23:0] period_ff;
  logic        dph_wr_ff;
  logic [7:0]  dph_addr_ff;
  logic [31:0] hrdata_ff;
  logic        sin_d_ff;
  logic [23:0] phase_ff;
  logic [23:0] nxt_phase;
  logic        cyc_start_ff;
  logic [7:0]  exp_cnt_ff;
  logic        exp_end_ff;
  logic        sync_out_ff;
  logic [32:0] target_ff;
  logic        pend_ff;
  logic [13:0] rem_ff;
  logic        acq_en_ff;
  logic        ana_out_en_ff;
  logic        dig_out_en_ff;
  logic        ana_hold_ff;
  logic        capv_ff;
  logic [23:0] cap_ff;
  logic        st_v_ff [2];
  logic [23:0] st_d_ff [2];
  logic        tdiff_valid_ff;
  logic [23:0] tdiff_ff;

  mtc_mode_e   mode;
  mtc_role_e   role;
  logic        pol;
  logic        sin_s;
  logic        act;
  logic        act_d;
  logic        edge_evt;
  logic        sync_rise;
  logic        tick;
  logic        acc;
  logic        sw_start;
  logic        sw_stop;
  logic [31:0] enc_pos;
  logic        enc_evt;
  logic        evt;
  logic        trig;
  logic        burst_go;
  logic [13:0] burst_load;
  logic        gate;
  logic [31:0] rd_data;

  mtc_pin_if pif ();
  assign pif.raw = sync_in;  // see RULE_01

  mtc_sync2 u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .pins    (pif.sync_side)
  );

  assign mode  = mtc_mode_e'(ctrl_ff[`MTC_F_MODE]);
  assign role  = mtc_role_e'(ctrl_ff[`MTC_F_ROLE]);
  assign pol   = ctrl_ff[`MTC_F_POL];
  assign sin_s = pif.sync;  // see RULE_21

  // Active level and selected edge share one polarity bit
  assign act       = pol ? sin_s : ~sin_s;
  assign act_d     = pol ? sin_d_ff : ~sin_d_ff;
  assign edge_evt  = act & ~act_d;  // see RULE_08
  assign sync_rise = sin_s & ~sin_d_ff;

  // Bus slave: zero wait states, always OKAY
  assign acc = hsel & htrans[1] & hready;
  assign sw_start = dph_wr_ff && dph_addr_ff == `MTC_A_CMD
                    && hwdata[`MTC_F_START];
  assign sw_stop  = dph_wr_ff && dph_addr_ff == `MTC_A_CMD
                    && hwdata[`MTC_F_STOP];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff   <= 1'b0;
      dph_addr_ff <= 8'h00;
    end else if (ce) begin
      dph_wr_ff <= acc & hwrite;
      if (acc) begin
        dph_addr_ff <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff   <= `MTC_R_CTRL;  // see RULE_02
      count_ff  <= `MTC_R_COUNT;
      step_ff   <= `MTC_R_STEP;
      lower_ff  <= `MTC_R_LOWER;
      upper_ff  <= `MTC_R_UPPER;
      period_ff <= `MTC_R_PERIOD;
    end else if (ce && dph_wr_ff) begin
      case (dph_addr_ff)
        `MTC_A_CTRL:   ctrl_ff   <= hwdata[8:0];
        `MTC_A_COUNT:  count_ff  <= hwdata[13:0];
        `MTC_A_STEP:   step_ff   <= hwdata;
        `MTC_A_LOWER:  lower_ff  <= hwdata;
        `MTC_A_UPPER:  upper_ff  <= hwdata;
        `MTC_A_PERIOD: period_ff <= hwdata[23:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (haddr[7:0])
      `MTC_A_CTRL:   rd_data = {23'h00_0000, ctrl_ff};
      `MTC_A_COUNT:  rd_data = {18'h0_0000, count_ff};
      `MTC_A_STEP:   rd_data = step_ff;
      `MTC_A_LOWER:  rd_data = lower_ff;
      `MTC_A_UPPER:  rd_data = upper_ff;
      `MTC_A_PERIOD: rd_data = {8'h00, period_ff};
      `MTC_A_STATUS: rd_data = {16'h0000, rem_ff, pend_ff,
                                ana_out_en_ff};
      `MTC_A_TDIFF:  rd_data = {8'h00, tdiff_ff};
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (ce && acc && !hwrite) begin
      hrdata_ff <= rd_data;
    end
  end

  // Cycle timebase: own counter, or sync pulses in slave role
  assign tick = (role == R_SLAVE) ? sync_rise  // see RULE_19
              : (phase_ff >= period_ff - 24'h00_0001);  // see RULE_03
  // Saturate so a silent master cannot wrap the phase
  assign nxt_phase = tick ? 24'h00_0000
                   : (&phase_ff) ? phase_ff : phase_ff + 24'h00_0001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sin_d_ff     <= 1'b0;
      phase_ff     <= 24'h00_0000;
      cyc_start_ff <= 1'b0;
      sync_out_ff  <= 1'b0;
    end else if (ce) begin
      sin_d_ff     <= sin_s;
      phase_ff     <= nxt_phase;
      cyc_start_ff <= tick;
      // Half-period high reaches the 5 us minimum only for periods of 2500 cycles or more
      sync_out_ff  <= (role == R_MASTER)
                      && nxt_phase < {1'b0, period_ff[23:1]};  // see RULE_18
    end
  end

  // Exposure end trails cycle start by a fixed offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_cnt_ff <= 8'h00;
      exp_end_ff <= 1'b0;
    end else if (ce) begin
      exp_end_ff <= (exp_cnt_ff == EXP_CYC);  // see RULE_17
      if (tick) begin
        exp_cnt_ff <= 8'h01;
      end else if (exp_cnt_ff == EXP_CYC) begin
        exp_cnt_ff <= 8'h00;
      end else if (exp_cnt_ff != 8'h00) begin
        exp_cnt_ff <= exp_cnt_ff + 8'h01;
      end
    end
  end

  // Encoder trigger grid: lower, lower+step, ... up to upper
  always_comb begin
    case (ctrl_ff[`MTC_F_ENC])
      2'h1:    enc_pos = enc_pos_1;
      2'h2:    enc_pos = enc_pos_2;
      default: enc_pos = enc_pos_0;
    endcase
  end
  assign enc_evt = (mode == M_ENC) && enc_pos >= lower_ff
                   && enc_pos <= upper_ff
                   && {1'b0, enc_pos} >= target_ff;  // see RULE_12

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_ff <= 33'h0_0000_0000;
    end else if (ce) begin
      if (mode != M_ENC || enc_pos < lower_ff) begin
        target_ff <= {1'b0, lower_ff};
      end else if (enc_evt) begin
        target_ff <= target_ff + {1'b0, step_ff};  // see RULE_12
      end
    end
  end

  // Burst start events per mode
  assign evt = (mode == M_EDGE && edge_evt)  // see RULE_08
             | (mode == M_SOFT && sw_start)  // see RULE_10
             | enc_evt;  // see RULE_11
  assign trig = evt | (mode == M_LEVEL && edge_evt);
  assign burst_load = (mode == M_ENC || count_ff == 14'h0000)
                      ? 14'h0001 : count_ff;
  assign burst_go = (pend_ff | evt | rem_ff != 14'h0000) & ~sw_stop;

  always_comb begin
    case (mode)
      M_NONE:  gate = 1'b1;  // see RULE_02
      M_LEVEL: gate = act;  // see RULE_06
      M_EDGE:  gate = burst_go;
      M_SOFT:  gate = burst_go;
      M_ENC:   gate = burst_go;
      default: gate = 1'b1;
    endcase
  end

  // Event pending until the next cycle boundary; set wins over the stop clear, the boundary clear wins over set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= 1'b0;
    end else if (ce) begin
      // An event on the boundary itself is consumed by that boundary
      if (evt && !tick) begin
        pend_ff <= 1'b1;
      end else if (tick || sw_stop) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem_ff <= 14'h0000;
    end else if (ce) begin
      if (sw_stop || mode == M_NONE || mode == M_LEVEL) begin
        rem_ff <= 14'h0000;  // see RULE_10
      end else if (tick) begin
        if (pend_ff || evt) begin
          rem_ff <= burst_load - 14'h0001;  // see RULE_08
        end else if (rem_ff != 14'h0000) begin
          rem_ff <= rem_ff - 14'h0001;
        end
      end
    end
  end

  // Gates change only on cycle boundaries, never the cycle rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_en_ff     <= 1'b0;
      ana_out_en_ff <= 1'b0;
      dig_out_en_ff <= 1'b0;
      ana_hold_ff   <= 1'b0;
    end else if (ce && tick) begin
      // Same boundary for both variants keeps the latency equal
      acq_en_ff     <= ctrl_ff[`MTC_F_VAR] | gate;  // see RULE_13 RULE_14
      ana_out_en_ff <= gate;  // see RULE_04
      dig_out_en_ff <= gate;  // see RULE_15
      ana_hold_ff   <= ~gate;  // see RULE_09
    end
  end

  // Trigger time difference: first event per cycle is captured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capv_ff <= 1'b0;
      cap_ff  <= 24'h00_0000;
    end else if (ce) begin
      if (tick) begin
        capv_ff <= 1'b0;
      end else if (trig && !capv_ff) begin
        capv_ff <= 1'b1;
        cap_ff  <= phase_ff;  // see RULE_16
      end
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_tdiff
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        st_v_ff[i] <= 1'b0;
        st_d_ff[i] <= 24'h00_0000;
      end else if (ce && tick) begin
        if (i == 0) begin
          st_v_ff[i] <= capv_ff | trig;
          st_d_ff[i] <= capv_ff ? cap_ff : phase_ff;
        end else begin
          st_v_ff[i] <= st_v_ff[i-1];  // see RULE_16
          st_d_ff[i] <= st_d_ff[i-1];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdiff_valid_ff <= 1'b0;
      tdiff_ff       <= 24'h00_0000;
    end else if (ce) begin
      tdiff_valid_ff <= tick & st_v_ff[1];
      if (tick && st_v_ff[1]) begin
        tdiff_ff <= st_d_ff[1];  // see RULE_16
      end
    end
  end

  assign hrdata      = hrdata_ff;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign sync_out    = sync_out_ff;
  assign cyc_start   = cyc_start_ff;
  assign exp_end     = exp_end_ff;
  assign acq_en      = acq_en_ff;
  assign ana_out_en  = ana_out_en_ff;
  assign dig_out_en  = dig_out_en_ff;
  assign ana_hold    = ana_hold_ff;
  assign tdiff_valid = tdiff_valid_ff;
  assign tdiff       = tdiff_ff;

  default clocking cb @(posedge hclk iff ce);
  endclocking
  default disable iff (!hresetn);

  sequence s_boundary;
    cyc_start_ff;
  endsequence
  sequence s_stop_cmd;
    sw_stop;
  endsequence

  a_free_run: assert property (  // see RULE_02
    s_boundary and $past(mode) == M_NONE |-> ana_out_en_ff)
    else $error("free run cycle not emitted");
  a_rate_fixed: assert property (  // see RULE_03
    s_boundary and $past(role) != R_SLAVE
    |-> $past(phase_ff) >= $past(period_ff) - 24'h00_0001)
    else $error("cycle length differs from period");
  a_paths_equal: assert property (  // see RULE_04
    ana_out_en_ff == dig_out_en_ff)
    else $error("analog and digital gates differ");
  a_level_gate: assert property (  // see RULE_06
    s_boundary and $past(mode) == M_LEVEL |-> ana_out_en_ff == $past(act))
    else $error("level gate wrong");
  a_burst_bound: assert property (  // see RULE_08
    rem_ff < 14'h3FFF)
    else $error("burst counter out of range");
  a_hold_last: assert property (  // see RULE_09
    s_boundary and !ana_out_en_ff |-> ana_hold_ff ##1 ana_hold_ff)
    else $error("analog not held after burst");
  a_stop_clears: assert property (  // see RULE_10
    s_stop_cmd |=> rem_ff == 14'h0000 && !pend_ff)
    else $error("stop did not end burst");
  a_out_variant: assert property (  // see RULE_14
    s_boundary and $past(ctrl_ff[`MTC_F_VAR]) |-> acq_en_ff)
    else $error("output variant skipped acquisition");
  a_tdiff_align: assert property (  // see RULE_16
    tdiff_valid_ff |-> cyc_start_ff)
    else $error("time difference off boundary");
  a_exposure_ofs: assert property (  // see RULE_17
    s_boundary ##1 !cyc_start_ff [*8] |-> ##17 exp_end_ff)
    else $error("exposure end not 25 cycles after start");
  a_master_sync: assert property (  // see RULE_18
    s_boundary and $past(role) == R_MASTER |-> sync_out_ff)
    else $error("master sync not high at cycle start");
  a_slave_cycle: assert property (  // see RULE_19
    s_boundary and $past(role) == R_SLAVE |-> $past(sync_rise))
    else $error("slave cycle without sync pulse");
endmodule // mtc_top
`default_nettype wire

// ==== test/mtc_far_model.sv ====
/*
  Far side of the trigger block: trigger or sync source on the pin and
  three encoder counters. Assumes the bench calls its tasks right after
  a rising edge of hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module mtc_far_model (
  input  wire logic        hclk,
  output logic             sync_in,
  output logic      [31:0] enc_pos_0,
  output logic      [31:0] enc_pos_1,
  output logic      [31:0] enc_pos_2
);
  logic [31:0] pos [3];

  assign enc_pos_0 = pos[0];
  assign enc_pos_1 = pos[1];
  assign enc_pos_2 = pos[2];

  initial begin
    sync_in = 1'b0;
    for (int j = 0; j < 3; j++) pos[j] = 32'h0000_0000;
  end

  // Callers keep n at 1250 or more for pulses, above one cycle for levels
  task automatic hold(input logic v, input int n);
    sync_in <= v;
    repeat (n) @(posedge hclk);
  endtask

  // Idle counters park inside the window so a wrong select fires at once
  task automatic ramp(input int sel, input int lo, input int hi,
                      input int dt);
    for (int p = lo; p <= hi; p++) begin
      for (int j = 0; j < 3; j++) begin
        pos[j] <= (j == sel) ? 32'(p) : 32'h0000_0096;
      end
      repeat (dt) @(posedge hclk);
    end
  endtask
endmodule // mtc_far_model
`default_nettype wire

// ==== test/tb_top.sv ====
/*
  Self-checking bench of the trigger block: register reset values,
  free run, level, edge, software and encoder gating, trigger time,
  master and slave roles. Assumes mtc_top with a zero-wait slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top import mtc_pkg::*; ;
  logic        hclk, hresetn, ce, hsel, hwrite, sync_in;
  logic [31:0] haddr, hwdata, hrdata, enc0, enc1, enc2, x;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  logic  hready;
  logic        hreadyout, hresp, sync_out, cyc_start, exp_end, acq_en;
  logic        ana_out_en, dig_out_en, ana_hold, tdiff_valid, p;
  logic [23:0] tdiff;
  logic [15:0] seed = 16'h0048;
  int          n_errors, samples_checked, cyc, n, on, first, nb, d, sel;
  logic [7:0]  ra [8] = '{`MTC_A_CTRL, `MTC_A_COUNT, `MTC_A_CMD,
    `MTC_A_STEP, `MTC_A_LOWER, `MTC_A_UPPER, `MTC_A_PERIOD, 8'h40};
  logic [31:0] rv [8] = '{32'(`MTC_R_CTRL), 32'(`MTC_R_COUNT),
    32'h0000_0000, `MTC_R_STEP, `MTC_R_LOWER, `MTC_R_UPPER,
    32'(`MTC_R_PERIOD), 32'h0000_0000};

  assign hready = hreadyout;

  mtc_top mtc_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sync_in(sync_in),
    .enc_pos_0(enc0), .enc_pos_1(enc1), .enc_pos_2(enc2),
    .sync_out(sync_out), .cyc_start(cyc_start), .exp_end(exp_end),
    .acq_en(acq_en), .ana_out_en(ana_out_en), .dig_out_en(dig_out_en),
    .ana_hold(ana_hold), .tdiff_valid(tdiff_valid), .tdiff(tdiff));

  mtc_far_model mtc_far_model_i (.hclk(hclk), .sync_in(sync_in),
    .enc_pos_0(enc0), .enc_pos_1(enc1), .enc_pos_2(enc2));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  function automatic int rnd(input int m);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return int'(seed) % m;
  endfunction

  function automatic logic [31:0] ctl(input mtc_mode_e m, input logic pl,
    input logic v, input mtc_role_e r, input logic [1:0] e);
    return {23'h00_0000, e, r, v, pl, m};
  endfunction

  function automatic int enc_hits(input int lo, input int hi, input int st);
    return (hi - lo) / st + 1;
  endfunction

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic [31:0] z;
    bus(1'b1, a, dt, z);
  endtask

  task automatic wcs;
    do @(posedge hclk); while (cyc_start !== 1'b1);
  endtask

  task automatic gap(output int g);
    g = 0;
    do begin @(posedge hclk); g++; end while (cyc_start !== 1'b1);
  endtask

  // Tally emitting cycles; dd >= 0 also checks the delayed trigger time
  task automatic cnt(input int nc, input int dd, output int o,
                     output int f);
    o = 0;
    f = -1;
    for (int i = 0; i < nc; i++) begin
      wcs;
      if (ana_out_en === 1'b1) begin
        o++;
        if (f < 0) f = i;
      end
      `CHK("dig gate", ana_out_en, dig_out_en)
      `CHK("analog hold", ~ana_out_en, ana_hold)
      if (dd >= 0 && i == 2) begin
        `CHK("tdiff valid", 1'b1, tdiff_valid)
        `CHK("tdiff", 1'b1, tdiff >= 24'(dd) && tdiff <= 24'(dd + 6))
      end
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 50000) begin
      n_errors++;
      conclude;
    end
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    ce    = 1'b1;
    hsize = 3'b010;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 32'h0000_0000, x);
      `CHK("reset value", rv[i], x)
      `CHK("okay resp", 1'b0, hresp)
    end
    wr(`MTC_A_PERIOD, 32'h0000_0028);
    wcs;
    wcs;
    `CHK("free run", 1'b1, ana_out_en)
    gap(n);
    `CHK("cycle length", 40, n)
    n = 0;
    do begin @(posedge hclk); n++; end while (exp_end !== 1'b1);
    `CHK("exposure end", `MTC_EXP_CYC, n)
    for (int v = 0; v < 2; v++) begin
      p = 1'(rnd(2));
      wr(`MTC_A_CTRL, ctl(M_LEVEL, p, 1'(v), R_LOCAL, 2'd0));
      mtc_far_model_i.hold(!p, 1300);
      wcs;
      `CHK("level off", 1'b0, ana_out_en)
      `CHK("acquire off", 1'(v), acq_en)
      mtc_far_model_i.hold(p, 1300);
      wcs;
      `CHK("level on", 1'b1, ana_out_en)
      `CHK("acquire on", 1'b1, acq_en)
    end
    for (int v = 0; v < 2; v++) begin
      nb = rnd(5) + 1;
      d = rnd(12) + 2;
      wr(`MTC_A_COUNT, 32'(nb));
      wr(`MTC_A_CTRL, ctl(M_EDGE, 1'(v), 1'(v), R_LOCAL, 2'd0));
      mtc_far_model_i.hold(!v, 1300);
      wcs;
      repeat (d) @(posedge hclk);
      fork
        mtc_far_model_i.hold(1'(v), 1300);
        cnt(nb + 4, d, on, first);
      join
      `CHK("burst length", nb, on)
      `CHK("burst start", 0, first)
    end
    nb = rnd(8) + 1;
    wr(`MTC_A_CTRL, ctl(M_SOFT, 1'b0, 1'b0, R_LOCAL, 2'd0));
    wr(`MTC_A_COUNT, 32'(nb));
    wr(`MTC_A_CMD, 32'h0000_0001);
    cnt(nb + 3, -1, on, first);
    `CHK("soft burst", nb, on)
    wr(`MTC_A_COUNT, 32'h0000_3FFF);
    wr(`MTC_A_CMD, 32'h0000_0001);
    wcs;
    wcs;
    `CHK("soft running", 1'b1, ana_out_en)
    wr(`MTC_A_CMD, 32'h0000_0002);
    cnt(4, -1, on, first);
    `CHK("soft stop", 0, on)
    sel = rnd(3);
    wr(`MTC_A_STEP, 32'h0000_000A);
    wr(`MTC_A_LOWER, 32'h0000_0064);
    wr(`MTC_A_UPPER, 32'h0000_00C8);
    wr(`MTC_A_CTRL, ctl(M_ENC, 1'b0, 1'b0, R_LOCAL, 2'(sel)));
    fork
      mtc_far_model_i.ramp(sel, 90, 215, 40);
      cnt(130, -1, on, first);
    join
    `CHK("encoder hits", enc_hits(100, 200, 10), on)
    wr(`MTC_A_CTRL, ctl(M_NONE, 1'b0, 1'b0, R_MASTER, 2'd0));
    wcs;
    wcs;
    n = 0;
    repeat (40) begin
      @(posedge hclk);
      n += int'(sync_out === 1'b1);
    end
    `CHK("sync high time", 20, n)
    mtc_far_model_i.hold(1'b0, 1300);
    wr(`MTC_A_CTRL, ctl(M_NONE, 1'b0, 1'b0, R_SLAVE, 2'd0));
    fork
      repeat (3) begin
        mtc_far_model_i.hold(1'b1, 1300);
        mtc_far_model_i.hold(1'b0, 1300);
      end
      begin
        wcs;
        wcs;
        gap(n);
      end
    join
    `CHK("slave cycle", 2600, n)
    conclude;
  end
endmodule // tb_top
`default_nettype wire
